// >>> logic/tim_flag.sv
// Timer interrupt flags, enables, fast clear and request outputs
`timescale 1ns/1ns
`default_nettype none
module tim_flag
   import tim_flag_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        srst,
   // Register port
   input  wire logic [3:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   // Timer events, same clock
   input  wire logic [3:0]  chan_event,
   input  wire logic [3:0]  chan_is_compare,
   input  wire logic [3:0]  capture_read,
   input  wire logic [3:0]  compare_write,
   input  wire logic        counter_wrap,
   input  wire logic [15:0] compare3_value,
   input  wire logic        accum_wrap,
   input  wire logic        counter_access,
   input  wire logic        accum_access,
   // Accumulator input pin, asynchronous
   input  wire logic        accum_input_pin,
   // Outputs
   output logic             counter_reset,
   output logic             accum_count_en,
   output logic [6:0]       irq
);
   logic [3:0] chan_flag_q;
   logic [3:0] chan_ie_q;
   logic       cnt_ovf_q;
   logic [7:0] rd_mux;
   logic [2:0] ctrl_q;
   logic [3:0] acc_ctrl_q;
   logic       ovf_q;
   logic       inf_q;
   logic [2:0] pin_q;
   logic [5:0] div_q;
   logic [7:0] rdata_q;

   wire fast_clr = ctrl_q[CTRL_FFC_BIT];
   wire wr_f1   = wr && addr == ADDR_FLAG1;
   wire wr_f2   = wr && addr == ADDR_FLAG2;
   wire wr_af   = wr && addr == ADDR_ACC_FLAG;
   // Fast clear per channel: capture read or compare write
   wire [3:0] chan_fc = {4{fast_clr}} &
      ((capture_read & ~chan_is_compare) | (compare_write & chan_is_compare)); // R3
   wire [3:0] chan_clr = (wr_f1 ? wdata[3:0] : 4'h0) | chan_fc; // R2
   wire cnt_ovf_clr = (wr_f2 && wdata[7]) || (fast_clr && counter_access); // R11
   wire acc_fc  = fast_clr && accum_access; // R6
   wire ovf_clr = (wr_af && wdata[ACC_OVF_BIT]) || acc_fc;
   wire inf_clr = (wr_af && wdata[ACC_INF_BIT]) || acc_fc;
   // Wrap suppressed when ch3 compare resets at top
   wire cnt_ovf_set = counter_wrap && !(ctrl_q[CTRL_CRST_BIT] && compare3_value == COUNT_TOP); // R10
   // Pin level after two-stage sync, in active polarity
   wire pin_s   = pin_q[1];
   wire pin_old = pin_q[2];
   wire act_now = pin_s ^ ~acc_ctrl_q[ACC_EDGE_BIT];
   wire act_old = pin_old ^ ~acc_ctrl_q[ACC_EDGE_BIT];
   // Event mode: entry into active level is the chosen edge; gated: leaving it
   wire inf_set = acc_ctrl_q[ACC_MODE_BIT] ? (act_old && !act_now) // R8
                                          : (act_now && !act_old); // R7
   wire div_tick = div_q == 6'h3f;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         chan_flag_q <= 4'h0; // R13
         chan_ie_q   <= 4'h0;
         cnt_ovf_q   <= 1'b0;
         ctrl_q      <= 3'h0;
         acc_ctrl_q  <= 4'h0;
         ovf_q       <= 1'b0;
         inf_q       <= 1'b0;
         pin_q       <= 3'h0;
         div_q       <= 6'h00;
         rdata_q     <= RESET_BYTE;
      end
      else
      begin
         // Set wins over any clear in the same cycle
         chan_flag_q <= (chan_flag_q & ~chan_clr) | chan_event; // R2 R4
         cnt_ovf_q   <= (cnt_ovf_q & ~cnt_ovf_clr) | cnt_ovf_set; // R9 R12
         ovf_q       <= (ovf_q & ~ovf_clr) | accum_wrap; // R5
         inf_q       <= (inf_q & ~inf_clr) | inf_set;
         pin_q       <= {pin_q[1:0], accum_input_pin};
         div_q       <= div_q + 6'h01;
         if (wr && addr == ADDR_IE)
            chan_ie_q <= wdata[3:0];
         if (wr && addr == ADDR_CTRL)
            ctrl_q <= wdata[2:0];
         if (wr && addr == ADDR_ACC_CTRL)
            acc_ctrl_q <= wdata[3:0];
         rdata_q <= rd_mux;
      end
   end

   always_comb
   begin
      rd_mux = 8'h00;
      if (rd)
      begin
         unique case (addr)
            ADDR_FLAG1:    rd_mux = {4'h0, chan_flag_q};
            ADDR_IE:       rd_mux = {4'h0, chan_ie_q};
            ADDR_FLAG2:    rd_mux = {cnt_ovf_q, 7'h00};
            ADDR_CTRL:     rd_mux = {5'h00, ctrl_q};
            ADDR_ACC_CTRL: rd_mux = {4'h0, acc_ctrl_q};
            ADDR_ACC_FLAG: rd_mux = {6'h00, inf_q, ovf_q};
            ADDR_IRQ:      rd_mux = {1'b0, irq};
            default:       rd_mux = 8'h00;
         endcase
      end
   end

   assign rdata = rdata_q;
   assign irq = {cnt_ovf_q && ctrl_q[CTRL_OVIE_BIT], // R9
                 inf_q && acc_ctrl_q[ACC_INI_BIT], // R8
                 ovf_q && acc_ctrl_q[ACC_OVI_BIT], // R5
                 chan_flag_q & chan_ie_q}; // R1
   assign counter_reset = ctrl_q[CTRL_CRST_BIT] && chan_event[3] && chan_is_compare[3]; // R14
   assign accum_count_en = acc_ctrl_q[ACC_MODE_BIT] ? (act_now && div_tick) // R15
                                                   : (act_now && !act_old);

   chk_chan_set: assert property (@(posedge clock) disable iff (srst)
      chan_event[0] |=> chan_flag_q[0]) else $error("channel flag not set"); // R2
   chk_chan_w1c: assert property (@(posedge clock) disable iff (srst)
      wr_f1 && wdata[1] && !chan_event[1] && !chan_fc[1] ##0 !fast_clr |=> !chan_flag_q[1])
      else $error("channel write-one clear failed"); // R2
   chk_fast_chan: assert property (@(posedge clock) disable iff (srst)
      fast_clr && compare_write[2] && chan_is_compare[2] && !chan_event[2] |=> !chan_flag_q[2])
      else $error("fast clear of channel failed"); // R3
   chk_acc_fast: assert property (@(posedge clock) disable iff (srst)
      fast_clr && accum_access && !accum_wrap && !inf_set |=> !ovf_q && !inf_q)
      else $error("accumulator fast clear failed"); // R6
   chk_wrap_supp: assert property (@(posedge clock) disable iff (srst)
      !cnt_ovf_q && counter_wrap && ctrl_q[CTRL_CRST_BIT] && compare3_value == COUNT_TOP |=> !cnt_ovf_q)
      else $error("overflow set despite suppression"); // R10
   chk_wrap_set: assert property (@(posedge clock) disable iff (srst)
      counter_wrap && !ctrl_q[CTRL_CRST_BIT] |=> cnt_ovf_q) else $error("overflow flag not set"); // R9
   chk_irq_gate: assert property (@(posedge clock) disable iff (srst)
      irq[6] == (cnt_ovf_q && ctrl_q[CTRL_OVIE_BIT]) && irq[4] == (ovf_q && acc_ctrl_q[ACC_OVI_BIT]))
      else $error("request not gated by enable"); // R1
   chk_reset_clear: assert property (@(posedge clock)
      srst |=> irq == 7'h00 && !cnt_ovf_q) else $error("flags not clear after reset"); // R13
   chk_edge_flag: assert property (@(posedge clock) disable iff (srst)
      inf_set |=> inf_q) else $error("input flag not set"); // R7
   cov_chan: cover property (@(posedge clock) chan_event[3] ##1 irq[3]);
   cov_wrap: cover property (@(posedge clock) cnt_ovf_set ##1 cnt_ovf_clr);
   cov_gate: cover property (@(posedge clock) acc_ctrl_q[ACC_MODE_BIT] && inf_set);
endmodule
`default_nettype wire

// >>> logic/tim_flag_pkg.sv
// Constants for the timer interrupt flag logic
// Operation
// R1: Seven interrupt requests, four channels, accumulator overflow and input, counter overflow, each enabled.
// R2: Channel capture or compare sets its flag; writing one clears it.
// R3: With fast clear, capture read or compare write clears that channel flag.
// R4: A set channel flag never blocks later captures or compares.
// R5: Accumulator wrap from ffff to 0000 sets overflow flag; enable gates request; write-one clears.
// R6: With fast clear, any accumulator count access clears all accumulator flags.
// R7: Event mode: each selected input edge sets accumulator input flag; write-one clears.
// R8: Gated mode: trailing edge of active gate level sets input flag; enable gates request.
// R9: Counter wrap sets counter overflow flag; enable gates request; write-one clears.
// R10: Channel 3 compare at ffff with counter reset enabled never sets counter overflow.
// R11: With fast clear, any counter access clears second flag register.
// R12: A set counter overflow flag does not block later overflow detection.
// R13: Reset clears every flag and enable bit.
// R14: Counter reset enable makes channel 3 compare reset the counter, even on shared pin.
// R15: Mode bit picks edge counting or divide-by-64 gated counting.
package tim_flag_pkg;
   localparam logic [3:0]  ADDR_FLAG1      = 4'h0;
   localparam logic [3:0]  ADDR_IE         = 4'h1;
   localparam logic [3:0]  ADDR_FLAG2      = 4'h2;
   localparam logic [3:0]  ADDR_CTRL       = 4'h3;
   localparam logic [3:0]  ADDR_ACC_CTRL   = 4'h4;
   localparam logic [3:0]  ADDR_ACC_FLAG   = 4'h5;
   localparam logic [3:0]  ADDR_IRQ        = 4'h6;
   localparam int          CTRL_FFC_BIT    = 0;
   localparam int          CTRL_CRST_BIT   = 1;
   localparam int          CTRL_OVIE_BIT   = 2;
   localparam int          ACC_MODE_BIT    = 0;
   localparam int          ACC_EDGE_BIT    = 1;
   localparam int          ACC_OVI_BIT     = 2;
   localparam int          ACC_INI_BIT     = 3;
   localparam int          ACC_OVF_BIT     = 0;
   localparam int          ACC_INF_BIT     = 1;
   localparam logic [15:0] COUNT_TOP       = 16'hffff;
   localparam logic [7:0]  RESET_BYTE      = 8'h00;
endpackage

// >>> verif/tb.sv
// Self-checking bench for the timer interrupt flag logic
`timescale 1ns/1ns
`default_nettype none
module tb;
   import tim_flag_pkg::*;
   logic        clock, srst, wr, rd, cwrap, awrap, cacc, aacc, pin, crst, acen;
   logic [3:0]  addr, ev, isc, crd, cwr;
   logic [7:0]  wdata, rdata;
   logic [6:0]  irq;
   logic [15:0] c3v;
   int          n_fail, samples_checked, n;

   tim_flag tim_flag_i(.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .chan_event(ev), .chan_is_compare(isc), .capture_read(crd), .compare_write(cwr),
      .counter_wrap(cwrap), .compare3_value(c3v), .accum_wrap(awrap), .counter_access(cacc),
      .accum_access(aacc), .accum_input_pin(pin), .counter_reset(crst), .accum_count_en(acen), .irq(irq));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      chk(rdata, exp);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_chan;
      wreg(ADDR_IE, 8'h0f);
      @(posedge clock) ev <= 4'hf;
      @(posedge clock) ev <= 4'h0;
      rreg(ADDR_FLAG1, 8'h0f);
      chk({1'b0, irq}, 8'h0f);
      wreg(ADDR_FLAG1, 8'h05);
      rreg(ADDR_FLAG1, 8'h0a);
      wreg(ADDR_IE, 8'h02);
      @(negedge clock);
      chk({1'b0, irq}, 8'h02);
      wreg(ADDR_CTRL, 8'h01);
      @(posedge clock) crd <= 4'h2;
      cwr <= 4'h8;
      isc <= 4'h8;
      @(posedge clock) crd <= 4'h0;
      cwr <= 4'h0;
      rreg(ADDR_FLAG1, 8'h00);
      $display("test chan done");
   endtask
   task automatic t_ovf;
      wreg(ADDR_CTRL, 8'h04);
      @(posedge clock) cwrap <= 1'b1;
      @(posedge clock) cwrap <= 1'b0;
      @(posedge clock) cwrap <= 1'b1;
      @(posedge clock) cwrap <= 1'b0;
      rreg(ADDR_FLAG2, 8'h80);
      chk({1'b0, irq}, 8'h40);
      wreg(ADDR_FLAG2, 8'h80);
      rreg(ADDR_FLAG2, 8'h00);
      wreg(ADDR_CTRL, 8'h06);
      @(posedge clock) cwrap <= 1'b1;
      c3v <= 16'hffff;
      ev <= 4'h8;
      isc <= 4'h8;
      @(negedge clock) chk({7'h00, crst}, 8'h01);
      @(posedge clock) cwrap <= 1'b0;
      ev <= 4'h0;
      rreg(ADDR_FLAG2, 8'h00);
      wreg(ADDR_FLAG1, 8'h0f);
      wreg(ADDR_CTRL, 8'h05);
      @(posedge clock) cwrap <= 1'b1;
      c3v <= 16'h0000;
      @(posedge clock) cwrap <= 1'b0;
      rreg(ADDR_FLAG2, 8'h80);
      @(posedge clock) cacc <= 1'b1;
      @(posedge clock) cacc <= 1'b0;
      rreg(ADDR_FLAG2, 8'h00);
      $display("test ovf done");
   endtask
   task automatic t_acc;
      wreg(ADDR_ACC_CTRL, 8'h0e);
      @(posedge clock) awrap <= 1'b1;
      @(posedge clock) awrap <= 1'b0;
      rreg(ADDR_ACC_FLAG, 8'h01);
      @(posedge clock) pin <= 1'b1;
      repeat (6) @(posedge clock);
      rreg(ADDR_ACC_FLAG, 8'h03);
      chk({1'b0, irq}, 8'h30);
      wreg(ADDR_ACC_FLAG, 8'h02);
      rreg(ADDR_ACC_FLAG, 8'h01);
      @(posedge clock) aacc <= 1'b1;
      @(posedge clock) aacc <= 1'b0;
      rreg(ADDR_ACC_FLAG, 8'h00);
      wreg(ADDR_ACC_CTRL, 8'h0b);
      n = 0;
      repeat (128) @(posedge clock) n += int'(acen);
      chk(n[7:0], 8'h02);
      rreg(ADDR_ACC_FLAG, 8'h00);
      @(posedge clock) pin <= 1'b0;
      repeat (6) @(posedge clock);
      rreg(ADDR_ACC_FLAG, 8'h02);
      chk({1'b0, irq}, 8'h20);
      $display("test acc done");
   endtask

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial
   begin
      #1ms;
      n_fail++;
      summarize();
   end
   initial
   begin
      {srst, wr, rd, cwrap, awrap, cacc, aacc, pin} = 8'h80;
      {addr, ev, isc, crd, cwr, wdata, c3v} = '0;
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      for (int a = 0; a < 7; a++) rreg(a[3:0], 8'h00);
      chk({1'b0, irq}, 8'h00);
      wreg(4'hf, 8'hff);
      rreg(4'hf, 8'h00);
      t_chan();
      t_ovf();
      t_acc();
      summarize();
   end
endmodule
`default_nettype wire
